// ===== core/dacs_sequencer.sv
// Conversion sequencer for two successive-approximation converters.
`timescale 1ns/1ns
`default_nettype none

module dacs_sequencer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire dacs_pkg::dacs_sfr_t sfr,
    output logic [7:0] sfr_rdata,
    input wire logic tmr2_ovf,
    input wire logic tmr3_ovf,
    input wire logic first_ext_start_pin,
    input wire logic second_ext_start_pin,
    input wire logic [15:0] first_sar_data,
    input wire logic [15:0] second_sar_data,
    output logic [1:0] track_out,
    output logic [1:0] sar_step,
    output logic [1:0] irq
);
    import dacs_pkg::*;

    // ********************************************************
    // State
    // ********************************************************
    dacs_ctrl_t ctrl_reg [2];
    logic [7:0] cfg_reg [2];
    dacs_state_t state_reg [2];
    logic [3:0] div_cnt_reg [2];
    logic [4:0] phase_reg [2];
    logic [1:0] flag_reg;
    logic [2:0] cal_reg;
    logic [15:0] res_reg [2];
    logic [1:0] ext_meta_reg;
    logic [1:0] ext_sync_reg;
    logic [1:0] ext_prev_reg;

    function automatic logic src_hit(input logic [2:0] mode, input logic own_busy,
                                     input logic ext_edge, input logic other_busy);
        case (mode)
            SRC_BUSY: src_hit = own_busy;
            SRC_TMR3: src_hit = tmr3_ovf;
            SRC_EXT: src_hit = ext_edge;
            SRC_TMR2: src_hit = tmr2_ovf;
            SRC_FIRST_BUSY: src_hit = other_busy;
            default: src_hit = 1'b0;
        endcase
    endfunction

    // ********************************************************
    // Decode
    // ********************************************************
    wire logic [1:0] wr_ctrl = {sfr.wr && sfr.addr == ADDR_CTRL1, sfr.wr && sfr.addr == ADDR_CTRL0};
    wire logic [1:0] busy_wr = wr_ctrl & {2{sfr.wdata[CTRL_BUSY_BIT]}};
    wire logic wr_cfg0 = sfr.wr && sfr.addr == ADDR_CFG0;
    wire logic wr_cfg1 = sfr.wr && sfr.addr == ADDR_CFG1;
    wire logic [1:0] ext_edge = ext_sync_reg & ~ext_prev_reg;
    wire logic [1:0] tick = {div_cnt_reg[1] == 4'h0, div_cnt_reg[0] == 4'h0};
    wire logic [1:0] idle = {state_reg[1] == S_IDLE, state_reg[0] == S_IDLE};
    wire logic [1:0] busy = {state_reg[1] == S_TRACK || state_reg[1] == S_CONV,
                             state_reg[0] == S_TRACK || state_reg[0] == S_CONV};
    wire logic start0 = src_hit(ctrl_reg[0].mode, busy_wr[0], ext_edge[0], 1'b0);
    wire logic start1 = src_hit(ctrl_reg[1].mode, busy_wr[1], ext_edge[1], busy_wr[0]);
    wire logic [1:0] start = {start1, start0} & idle & {ctrl_reg[1].en, ctrl_reg[0].en};
    wire logic [2:0] cal_start = (wr_cfg1 && idle[1]) ? sfr.wdata[2:0] : 3'h0;
    wire logic [1:0] conv_done = {state_reg[1] == S_CONV && tick[1] && phase_reg[1] == 5'h00,
                                  state_reg[0] == S_CONV && tick[0] && phase_reg[0] == 5'h00};
    wire logic [15:0] diff_word = 16'(first_sar_data - second_sar_data);
    wire logic [1:0] flag_clr = wr_ctrl & ~{2{sfr.wdata[CTRL_DONE_BIT]}};

    // ********************************************************
    // Register file
    // ********************************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_reg[0] <= '0;
            ctrl_reg[1] <= '0;
            cfg_reg[0] <= CFG0_RESET;
            cfg_reg[1] <= CFG1_RESET;
        end
        else
        begin
            if (wr_ctrl[0])
                ctrl_reg[0] <= '{sfr.wdata[CTRL_EN_BIT], sfr.wdata[CTRL_TM_BIT],
                                 sfr.wdata[CTRL_IE_BIT], {1'b0, sfr.wdata[3:2]}};
            if (wr_ctrl[1])
                ctrl_reg[1] <= '{sfr.wdata[CTRL_EN_BIT], sfr.wdata[CTRL_TM_BIT],
                                 sfr.wdata[CTRL_IE_BIT], sfr.wdata[3:1]};
            if (wr_cfg0)
                cfg_reg[0] <= sfr.wdata;
            if (wr_cfg1)
                cfg_reg[1] <= {sfr.wdata[7:3], 3'h0};
        end
    end

    // Set wins over a software clear landing in the same cycle.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            flag_reg <= 2'h0;
        else
            flag_reg <= conv_done | (flag_reg & ~flag_clr);
    end

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ext_meta_reg <= 2'h0;
            ext_sync_reg <= 2'h0;
            ext_prev_reg <= 2'h0;
        end
        else
        begin
            ext_meta_reg <= {second_ext_start_pin, first_ext_start_pin};
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end

    // ********************************************************
    // Sequencers
    // ********************************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 2; i++)
            begin
                state_reg[i] <= S_IDLE;
                div_cnt_reg[i] <= 4'h0;
                phase_reg[i] <= 5'h00;
            end
            cal_reg <= 3'h0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                // The divider runs freely, so a start may wait up to one period.
                div_cnt_reg[i] <= tick[i] ? cfg_reg[i][7:CFG_DIV_LSB] : div_cnt_reg[i] - 4'h1;
                case (state_reg[i])
                    S_IDLE:
                    begin
                        if (start[i])
                        begin
                            if (ctrl_reg[i].mode == SRC_EXT || !ctrl_reg[i].tm)
                            begin
                                state_reg[i] <= S_CONV;
                                phase_reg[i] <= CONV_CLKS - 5'h01;
                            end
                            else
                            begin
                                state_reg[i] <= S_TRACK;
                                phase_reg[i] <= TRACK_CLKS - 5'h01;
                            end
                        end
                        else if (i == 1 && cal_start != 3'h0)
                        begin
                            state_reg[i] <= S_CAL;
                            phase_reg[i] <= CAL_CLKS;
                        end
                    end
                    S_TRACK, S_CONV, S_CAL:
                    begin
                        if (!ctrl_reg[i].en && state_reg[i] != S_CAL)
                            state_reg[i] <= S_IDLE;
                        else if (tick[i] && phase_reg[i] == 5'h00)
                        begin
                            state_reg[i] <= (state_reg[i] == S_TRACK) ? S_CONV : S_IDLE;
                            phase_reg[i] <= CONV_CLKS - 5'h01;
                        end
                        else if (tick[i])
                            phase_reg[i] <= phase_reg[i] - 5'h01;
                    end
                    default: state_reg[i] <= S_IDLE;
                endcase
            end
            if (cal_start != 3'h0 && !start[1])
                cal_reg <= cal_start;
            else if (state_reg[1] != S_CAL)
                cal_reg <= 3'h0;
        end
    end

    // ********************************************************
    // Results
    // ********************************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            res_reg[0] <= 16'h0000;
            res_reg[1] <= 16'h0000;
        end
        else
        begin
            if (conv_done[0])
                res_reg[0] <= cfg_reg[0][CFG_DIFF_BIT] ? diff_word : first_sar_data;
            if (conv_done[1])
                res_reg[1] <= second_sar_data;
        end
    end

    // ********************************************************
    // Outputs and read data
    // ********************************************************
    wire logic [7:0] ctrl0_rd = {ctrl_reg[0].en, ctrl_reg[0].tm, flag_reg[0], busy[0],
                                 ctrl_reg[0].mode[1:0], 1'b0, ctrl_reg[0].ie};
    wire logic [7:0] ctrl1_rd = {ctrl_reg[1].en, ctrl_reg[1].tm, flag_reg[1], busy[1],
                                 ctrl_reg[1].mode, ctrl_reg[1].ie};
    wire logic [7:0] cfg1_rd = {cfg_reg[1][7:3], cal_reg & {3{state_reg[1] == S_CAL}}};
    wire logic [7:0] rd_mux = (sfr.addr == ADDR_CTRL0) ? ctrl0_rd :
                              (sfr.addr == ADDR_CTRL1) ? ctrl1_rd :
                              (sfr.addr == ADDR_CFG0) ? cfg_reg[0] :
                              (sfr.addr == ADDR_CFG1) ? cfg1_rd :
                              (sfr.addr == ADDR_RES0H) ? res_reg[0][15:8] :
                              (sfr.addr == ADDR_RES0L) ? res_reg[0][7:0] :
                              (sfr.addr == ADDR_RES1H) ? res_reg[1][15:8] : res_reg[1][7:0];

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sfr_rdata <= 8'h00;
            track_out <= 2'h0;
            sar_step <= 2'h0;
            irq <= 2'h0;
        end
        else
        begin
            sfr_rdata <= rd_mux;
            for (int i = 0; i < 2; i++)
            begin
                track_out[i] <= ctrl_reg[i].en && state_reg[i] != S_CONV;
                sar_step[i] <= tick[i] && state_reg[i] == S_CONV;
                irq[i] <= flag_reg[i] && ctrl_reg[i].ie;
            end
        end
    end

endmodule

`default_nettype wire

// ===== core/dacs_pkg.sv
// Shared constants, types and register layout of the dual converter sequencer.
package dacs_pkg;

    // ********************************************************
    // Register addresses
    // ********************************************************
    localparam logic [2:0] ADDR_CTRL0 = 3'h0;
    localparam logic [2:0] ADDR_CTRL1 = 3'h1;
    localparam logic [2:0] ADDR_CFG0 = 3'h2;
    localparam logic [2:0] ADDR_CFG1 = 3'h3;
    localparam logic [2:0] ADDR_RES0H = 3'h4;
    localparam logic [2:0] ADDR_RES0L = 3'h5;
    localparam logic [2:0] ADDR_RES1H = 3'h6;
    localparam logic [2:0] ADDR_RES1L = 3'h7;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_TM_BIT = 6;
    localparam int CTRL_DONE_BIT = 5;
    localparam int CTRL_BUSY_BIT = 4;
    localparam int CTRL_IE_BIT = 0;
    localparam int CFG_DIV_LSB = 4;
    localparam int CFG_SCAL_BIT = 3;
    localparam int CFG_DIFF_BIT = 0;

    // ********************************************************
    // Reset values and timing counts in conversion clocks
    // ********************************************************
    localparam logic [7:0] CFG0_RESET = 8'hF0;
    localparam logic [7:0] CFG1_RESET = 8'hF0;
    localparam logic [4:0] TRACK_CLKS = 5'h03;
    localparam logic [4:0] CONV_CLKS = 5'h10;
    localparam logic [4:0] CAL_CLKS = 5'h1F;

    // ********************************************************
    // Start sources
    // ********************************************************
    localparam logic [2:0] SRC_BUSY = 3'h0;
    localparam logic [2:0] SRC_TMR3 = 3'h1;
    localparam logic [2:0] SRC_EXT = 3'h2;
    localparam logic [2:0] SRC_TMR2 = 3'h3;
    localparam logic [2:0] SRC_FIRST_BUSY = 3'h4;

    typedef enum {S_IDLE, S_TRACK, S_CONV, S_CAL} dacs_state_t;

    typedef struct packed {
        logic en;
        logic tm;
        logic ie;
        logic [2:0] mode;
    } dacs_ctrl_t;

    typedef struct packed {
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } dacs_sfr_t;

endpackage

// ===== verif/dacs_props.sv
// Port checker for the dual converter sequencer.
`timescale 1ns/1ns
`default_nettype none
module dacs_props (
    input wire logic ref_clk,
    input wire logic rst,
    input wire dacs_pkg::dacs_sfr_t sfr,
    input wire logic [7:0] sfr_rdata,
    input wire logic tmr2_ovf,
    input wire logic tmr3_ovf,
    input wire logic first_ext_start_pin,
    input wire logic second_ext_start_pin,
    input wire logic [15:0] first_sar_data,
    input wire logic [15:0] second_sar_data,
    input wire logic [1:0] track_out,
    input wire logic [1:0] sar_step,
    input wire logic [1:0] irq
);
    import dacs_pkg::*;
    // ****
    // Shadows of written fields and step counters
    // ****
    logic [3:0] div0_reg, div1_reg;
    logic en0_reg, ie0_reg;
    logic [4:0] gap0_reg, gap1_reg, steps0_reg;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Gap counters saturate so that idle stretches never wrap into a false period.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            {div0_reg, div1_reg, en0_reg, ie0_reg} <= 10'h3FC;
            {gap0_reg, gap1_reg, steps0_reg} <= 15'h7FE0;
        end
        else
        begin
            if (sfr.wr && sfr.addr == ADDR_CFG0)
                div0_reg <= sfr.wdata[7:4];
            if (sfr.wr && sfr.addr == ADDR_CFG1)
                div1_reg <= sfr.wdata[7:4];
            if (sfr.wr && sfr.addr == ADDR_CTRL0)
                {en0_reg, ie0_reg} <= {sfr.wdata[CTRL_EN_BIT], sfr.wdata[CTRL_IE_BIT]};
            gap0_reg <= sar_step[0] ? 5'h01 : gap0_reg + {4'h0, gap0_reg != 5'h1F};
            gap1_reg <= sar_step[1] ? 5'h01 : gap1_reg + {4'h0, gap1_reg != 5'h1F};
            steps0_reg <= track_out[0] ? 5'h00 : steps0_reg + {4'h0, sar_step[0]};
        end
    end
    AST_STEP_NOT_TRACK0: assert property (sar_step[0] |-> !track_out[0])
        else $error("first steps while tracking");
    AST_STEP_NOT_TRACK1: assert property (sar_step[1] |-> !track_out[1])
        else $error("second steps while tracking");
    AST_PERIOD0: assert property (sar_step[0] && gap0_reg < 5'h11 |->
        gap0_reg == {1'b0, div0_reg} + 5'h01) else $error("first clock period wrong");
    AST_PERIOD1: assert property (sar_step[1] && gap1_reg < 5'h11 |->
        gap1_reg == {1'b0, div1_reg} + 5'h01) else $error("second clock period wrong");
    AST_STEPS_PER_CONV: assert property ($rose(track_out[0]) && steps0_reg != 5'h00 |->
        steps0_reg + {4'h0, sar_step[0]} == CONV_CLKS) else $error("step count wrong");
    AST_IRQ_NEEDS_IE: assert property (irq[0] |-> ie0_reg || $past(ie0_reg))
        else $error("interrupt while disabled");
    AST_IRQ_CLEARS: assert property (irq[0] && sfr.wr && sfr.addr == ADDR_CTRL0 &&
        !sfr.wdata[CTRL_IE_BIT] |-> ##[1:2] !irq[0]) else $error("interrupt stuck");
    // A conversion cut by clearing enable may still show its last step one cycle later.
    AST_IDLE_QUIET: assert property (!en0_reg && !$past(en0_reg) && !$past(en0_reg, 2) |->
        !track_out[0] && !sar_step[0]) else $error("disabled converter active");
endmodule
`default_nettype wire

// ===== verif/dacs_start_src.sv
// Model of the timers and external start pins facing the sequencer.
`timescale 1ns/1ns
`default_nettype none
module dacs_start_src (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic [2:0] src,
    input wire logic unit,
    output logic tmr2_ovf,
    output logic tmr3_ovf,
    output logic [1:0] pin
);
    import dacs_pkg::*;
    // Pins move off the clock grid, as a board signal would.
    initial
    begin
        {tmr2_ovf, tmr3_ovf, pin} = 4'h0;
        forever
        begin
            @(posedge ref_clk);
            tmr3_ovf <= go && src == SRC_TMR3;
            tmr2_ovf <= go && src == SRC_TMR2;
            if (go && src == SRC_EXT)
            begin
                #1 pin[unit] = 1'b1;
                repeat (8) @(posedge ref_clk);
                #1 pin[unit] = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking testbench for the dual converter sequencer.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import dacs_pkg::*;
    logic ref_clk, rst, go, unit, rd_tag, tmr2_ovf, tmr3_ovf;
    logic [2:0] src;
    logic [7:0] sfr_rdata;
    logic [1:0] pin, track_out, sar_step, irq;
    logic [15:0] sar0, sar1;
    dacs_sfr_t sfr;
    logic [7:0] exp_q[$];
    int fails, checks_done;
    dacs_sequencer dut_u (.ref_clk(ref_clk), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .tmr2_ovf(tmr2_ovf), .tmr3_ovf(tmr3_ovf), .first_ext_start_pin(pin[0]),
        .second_ext_start_pin(pin[1]), .first_sar_data(sar0), .second_sar_data(sar1),
        .track_out(track_out), .sar_step(sar_step), .irq(irq));
    dacs_start_src src_u (.ref_clk(ref_clk), .go(go), .src(src), .unit(unit),
        .tmr2_ovf(tmr2_ovf), .tmr3_ovf(tmr3_ovf), .pin(pin));
    // ****
    // Bus tasks and checking
    // ****
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want)
        begin
            fails++;
            $display("wrong value at %0t: read %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic test_done;
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1 sfr = '{1'b1, a, d};
        @(posedge ref_clk);
        #1 sfr.wr = 1'b0;
    endtask
    // Read data is registered, so the note is taken on the second edge after the address is set.
    task automatic rd(input logic [2:0] a, input logic [7:0] want);
        @(posedge ref_clk);
        #1 sfr.addr = a;
        @(posedge ref_clk);
        #1 rd_tag = 1'b1;
        exp_q.push_back(want);
        @(posedge ref_clk);
        #1 rd_tag = 1'b0;
    endtask
    always @(posedge ref_clk)
        if (rd_tag === 1'b1)
            check(sfr_rdata, exp_q.pop_front());
    task automatic conv(input logic u, input logic [2:0] m, input logic [15:0] want);
        logic [7:0] c;
        int n;
        c = u ? {2'h3, 2'h0, m, 1'b1} : {2'h2, 2'h0, m[1:0], 2'h1};
        wr({2'h0, u}, c);
        repeat (20) @(posedge ref_clk);
        rd({2'h0, u}, c);
        if (m == SRC_BUSY)
            wr({2'h0, u}, c | 8'h10);
        else if (m == SRC_FIRST_BUSY)
            wr(ADDR_CTRL0, 8'h90);
        else
        begin
            @(posedge ref_clk);
            #1 {go, src, unit} = {1'b1, m, u};
            @(posedge ref_clk);
            #1 go = 1'b0;
        end
        if (m == SRC_BUSY && !u)
            rd(ADDR_CTRL0, c | 8'h10);
        for (n = 0; n < 2000 && irq[u] !== 1'b1; n++)
            @(posedge ref_clk);
        if (n == 2000)
        begin
            fails++;
            test_done;
        end
        rd({2'h0, u}, c | 8'h20);
        rd({1'b1, u, 1'b0}, want[15:8]);
        rd({1'b1, u, 1'b1}, want[7:0]);
        wr({1'b1, u, 1'b0}, ~want[15:8]);
        rd({1'b1, u, 1'b0}, want[15:8]);
        wr(ADDR_CTRL0, 8'h00);
        wr(ADDR_CTRL1, 8'h00);
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial
    begin
        logic [3:0] dv;
        int k;
        {rst, go, unit, rd_tag, src} = 7'h40;
        sfr = '0;
        {sar0, sar1} = 32'h0;
        fails = 0;
        checks_done = 0;
        void'($urandom(32'hC1B90FE7));
        repeat (12) @(posedge ref_clk);
        #1 rst = 1'b0;
        for (k = 0; k < 4; k++)
            rd(k[2:0], k < 2 ? 8'h00 : k == 2 ? CFG0_RESET : CFG1_RESET);
        for (k = 0; k < 12; k++)
        begin
            if (k[3:1] > (k[0] ? 3'h4 : 3'h3))
                continue;
            dv = k == 2 ? 4'h0 : k == 3 ? 4'hF : 4'($urandom);
            {sar0, sar1} = 32'($urandom);
            wr({2'h1, k[0]}, {dv, 4'h0});
            rd({2'h1, k[0]}, {dv, 4'h0});
            conv(k[0], k[3:1], k[0] ? sar1 : sar0);
        end
        {sar0, sar1} = 32'($urandom);
        wr(ADDR_CFG0, 8'h01);
        conv(1'b1, SRC_BUSY, sar1);
        conv(1'b0, SRC_BUSY, sar0 - sar1);
        for (k = 0; k < 3; k++)
        begin
            wr(ADDR_CFG1, 8'h01 << k);
            wr(ADDR_CFG1, 8'h00);
            rd(ADDR_CFG1, 8'h01 << k);
            repeat (60) @(posedge ref_clk);
            rd(ADDR_CFG1, 8'h00);
        end
        test_done;
    end
endmodule
bind dacs_sequencer dacs_props props_u (.ref_clk(ref_clk), .rst(rst), .sfr(sfr),
    .sfr_rdata(sfr_rdata), .tmr2_ovf(tmr2_ovf), .tmr3_ovf(tmr3_ovf),
    .first_ext_start_pin(first_ext_start_pin), .second_ext_start_pin(second_ext_start_pin),
    .first_sar_data(first_sar_data), .second_sar_data(second_sar_data),
    .track_out(track_out), .sar_step(sar_step), .irq(irq));
`default_nettype wire
